// File: rxa_pkg.sv
// Shared constants and types for the receiver channel settings bank
package rxa_pkg;

    // Register access port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Offsets covered by this slice
    localparam logic [7:0] OFS_RSVD_0A        = 8'h0A;
    localparam logic [7:0] OFS_RSVD_0B        = 8'h0B;
    localparam logic [7:0] OFS_RSVD_0C        = 8'h0C;
    localparam logic [7:0] OFS_CH3_BW_SWING   = 8'h0D;
    localparam logic [7:0] OFS_CH3_GAIN_OFS   = 8'h0E;
    localparam logic [7:0] OFS_RSVD_0F        = 8'h0F;
    localparam logic [7:0] OFS_RSVD_10        = 8'h10;
    localparam logic [7:0] OFS_RSVD_11        = 8'h11;
    localparam logic [7:0] OFS_RSVD_12        = 8'h12;
    localparam logic [7:0] OFS_CH4_BW_SWING   = 8'h13;
    localparam logic [7:0] SLICE_LO           = 8'h0A;
    localparam logic [7:0] SLICE_HI           = 8'h13;

    // Reset values
    localparam logic [7:0] RST_CH3_BW_SWING   = 8'h00;
    localparam logic [7:0] RST_CH3_GAIN_OFS   = 8'h00;
    localparam logic [7:0] RST_CH4_BW_SWING   = 8'h00;
    localparam logic [7:0] RD_ZERO            = 8'h00;

    // Field positions
    localparam int BW_MSB        = 7;
    localparam int BW_LSB        = 4;
    localparam int SWING_MSB     = 3;
    localparam int SWING_LSB     = 0;
    localparam int SLEEP_BIT     = 7;
    localparam int BUF_OFF_BIT   = 6;
    localparam int GAIN_MSB      = 5;
    localparam int GAIN_LSB      = 4;
    localparam int OFS_SIGN_BIT  = 3;
    localparam int OFS_MAG_MSB   = 2;
    localparam int OFS_MAG_LSB   = 0;
    localparam int SWING_HI_BIT  = 3;

    // Bandwidth trim codes
    localparam logic [3:0] BW_CODE_NOMINAL = 4'h0;
    localparam logic [3:0] BW_CODE_LOWER   = 4'h7;
    localparam logic [3:0] BW_CODE_RAISE   = 4'hF;

    // Gain codes and attenuation in dB
    localparam logic [1:0] GAIN_DEFAULT   = 2'h0;
    localparam logic [1:0] GAIN_NA        = 2'h1;
    localparam logic [1:0] GAIN_MEDIUM    = 2'h2;
    localparam logic [1:0] GAIN_MINIMUM   = 2'h3;
    localparam logic [3:0] GAIN_DB_NONE   = 4'h0;
    localparam logic [3:0] GAIN_DB_MEDIUM = 4'h4;
    localparam logic [3:0] GAIN_DB_MIN    = 4'h8;

    // Output swing in mVpp
    localparam int         SWING_W          = 10;
    localparam logic [9:0] SWING_STEP_MV    = 10'h032;
    localparam logic [9:0] SWING_HI_BASE_MV = 10'h0FA;
    localparam logic [9:0] SWING_RST_MV     = 10'h000;

    typedef enum logic [1:0] {
        RXA_BW_NOMINAL,
        RXA_BW_LOWER,
        RXA_BW_RAISE,
        RXA_BW_OTHER
    } rxa_bw_trim_t;

endpackage : rxa_pkg

// File: rxa_bw_swing_decode.sv
// Decoder for one bandwidth and swing register byte
`timescale 1ns/10ps
module rxa_bw_swing_decode (
    input  wire logic [7:0]         reg_value,
    output rxa_pkg::rxa_bw_trim_t   bw_trim,
    output logic [9:0]              swing_mv
);

    logic [3:0] bw_code;
    logic [3:0] swing_code;
    logic [9:0] swing_steps;

    always_comb begin
        bw_code     = reg_value[rxa_pkg::BW_MSB:rxa_pkg::BW_LSB];
        swing_code  = reg_value[rxa_pkg::SWING_MSB:rxa_pkg::SWING_LSB];
        swing_steps = 10'(swing_code[2:0]) * rxa_pkg::SWING_STEP_MV;
        // Trim class
        case (bw_code)
            rxa_pkg::BW_CODE_NOMINAL: bw_trim = rxa_pkg::RXA_BW_NOMINAL;
            rxa_pkg::BW_CODE_LOWER:   bw_trim = rxa_pkg::RXA_BW_LOWER;
            rxa_pkg::BW_CODE_RAISE:   bw_trim = rxa_pkg::RXA_BW_RAISE;
            default:                  bw_trim = rxa_pkg::RXA_BW_OTHER;
        endcase
        // Two overlapping swing ranges
        if (swing_code[rxa_pkg::SWING_HI_BIT]) begin
            swing_mv = 10'(rxa_pkg::SWING_HI_BASE_MV + swing_steps);
        end else begin
            swing_mv = swing_steps;
        end
    end

endmodule : rxa_bw_swing_decode

// File: rxa_gain_offset_decode.sv
// Decoder for the sleep, buffer, gain and offset register byte
`timescale 1ns/10ps
module rxa_gain_offset_decode (
    input  wire logic [7:0] reg_value,
    output logic            channel_sleep,
    output logic            output_buffer_off,
    output logic [3:0]      gain_atten_db,
    output logic            gain_code_na,
    output logic            offset_negative,
    output logic [2:0]      offset_mag
);

    logic [1:0] gain_code;

    always_comb begin
        gain_code         = reg_value[rxa_pkg::GAIN_MSB:rxa_pkg::GAIN_LSB];
        channel_sleep     = reg_value[rxa_pkg::SLEEP_BIT];
        output_buffer_off = reg_value[rxa_pkg::BUF_OFF_BIT];
        gain_code_na      = (gain_code == rxa_pkg::GAIN_NA);
        case (gain_code)
            rxa_pkg::GAIN_MEDIUM:  gain_atten_db = rxa_pkg::GAIN_DB_MEDIUM;
            rxa_pkg::GAIN_MINIMUM: gain_atten_db = rxa_pkg::GAIN_DB_MIN;
            default:               gain_atten_db = rxa_pkg::GAIN_DB_NONE;
        endcase
        // Sign and magnitude; both zero codes give no shift
        offset_mag      = reg_value[rxa_pkg::OFS_MAG_MSB:rxa_pkg::OFS_MAG_LSB];
        offset_negative = reg_value[rxa_pkg::OFS_SIGN_BIT] && (offset_mag != 3'h0);
    end

endmodule : rxa_gain_offset_decode

// File: rxa_channel_settings_bank.sv
// Settings register slice for channel 3 and channel 4 bandwidth and swing
`timescale 1ns/10ps
module rxa_channel_settings_bank (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wr_data,
    output logic [7:0]                reg_rd_data,
    output logic                      reg_rd_valid,
    output logic                      reg_hit,
    output logic                      reg_wr_ignored,
    output logic [3:0]                ch3_bw_trim_code,
    output rxa_pkg::rxa_bw_trim_t     ch3_bw_trim,
    output logic [3:0]                ch3_output_swing_code,
    output logic [9:0]                ch3_output_swing_mv,
    output logic                      ch3_channel_sleep,
    output logic                      ch3_output_buffer_off,
    output logic [3:0]                ch3_gain_atten_db,
    output logic                      ch3_gain_code_na,
    output logic                      ch3_decision_offset_neg,
    output logic [2:0]                ch3_decision_offset_mag,
    output logic [3:0]                ch4_bw_trim_code,
    output rxa_pkg::rxa_bw_trim_t     ch4_bw_trim,
    output logic [3:0]                ch4_output_swing_code,
    output logic [9:0]                ch4_output_swing_mv
);

    // Stored settings
    logic [7:0] ch3_bandwidth_swing;
    logic [7:0] ch3_gain_offset_power;
    logic [7:0] ch4_bandwidth_swing;
    logic [7:0] next_ch3_bandwidth_swing;
    logic [7:0] next_ch3_gain_offset_power;
    logic [7:0] next_ch4_bandwidth_swing;

    // Read path state
    logic [7:0] next_reg_rd_data;
    logic       next_reg_rd_valid;
    logic       next_reg_hit;
    logic       next_reg_wr_ignored;

    // Address decode
    logic       addr_in_slice;
    logic       sel_ch3_bw;
    logic       sel_ch3_gain;
    logic       sel_ch4_bw;
    logic       sel_reserved;

    // Decoder results
    rxa_pkg::rxa_bw_trim_t dec_ch3_bw_trim;
    rxa_pkg::rxa_bw_trim_t dec_ch4_bw_trim;
    logic [9:0]            dec_ch3_swing_mv;
    logic [9:0]            dec_ch4_swing_mv;
    logic                  dec_ch3_sleep;
    logic                  dec_ch3_buf_off;
    logic [3:0]            dec_ch3_gain_db;
    logic                  dec_ch3_gain_na;
    logic                  dec_ch3_ofs_neg;
    logic [2:0]            dec_ch3_ofs_mag;

    // Registered decoded outputs
    logic [3:0]            next_ch3_bw_trim_code;
    rxa_pkg::rxa_bw_trim_t next_ch3_bw_trim;
    logic [3:0]            next_ch3_output_swing_code;
    logic [9:0]            next_ch3_output_swing_mv;
    logic                  next_ch3_channel_sleep;
    logic                  next_ch3_output_buffer_off;
    logic [3:0]            next_ch3_gain_atten_db;
    logic                  next_ch3_gain_code_na;
    logic                  next_ch3_decision_offset_neg;
    logic [2:0]            next_ch3_decision_offset_mag;
    logic [3:0]            next_ch4_bw_trim_code;
    rxa_pkg::rxa_bw_trim_t next_ch4_bw_trim;
    logic [3:0]            next_ch4_output_swing_code;
    logic [9:0]            next_ch4_output_swing_mv;

    // Address decode
    always_comb begin
        addr_in_slice = (reg_addr >= rxa_pkg::SLICE_LO) && (reg_addr <= rxa_pkg::SLICE_HI);
        sel_ch3_bw    = (reg_addr == rxa_pkg::OFS_CH3_BW_SWING);
        sel_ch3_gain  = (reg_addr == rxa_pkg::OFS_CH3_GAIN_OFS);
        sel_ch4_bw    = (reg_addr == rxa_pkg::OFS_CH4_BW_SWING);
        sel_reserved  = addr_in_slice && !sel_ch3_bw && !sel_ch3_gain && !sel_ch4_bw;
    end

    // Register writes
    always_comb begin
        next_ch3_bandwidth_swing   = ch3_bandwidth_swing;
        next_ch3_gain_offset_power = ch3_gain_offset_power;
        next_ch4_bandwidth_swing   = ch4_bandwidth_swing;
        if (reg_wr_en && sel_ch3_bw) begin
            next_ch3_bandwidth_swing = reg_wr_data;
        end
        if (reg_wr_en && sel_ch3_gain) begin
            next_ch3_gain_offset_power = reg_wr_data;
        end
        if (reg_wr_en && sel_ch4_bw) begin
            next_ch4_bandwidth_swing = reg_wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ch3_bandwidth_swing   <= rxa_pkg::RST_CH3_BW_SWING;
            ch3_gain_offset_power <= rxa_pkg::RST_CH3_GAIN_OFS;
            ch4_bandwidth_swing   <= rxa_pkg::RST_CH4_BW_SWING;
        end else begin
            ch3_bandwidth_swing   <= next_ch3_bandwidth_swing;
            ch3_gain_offset_power <= next_ch3_gain_offset_power;
            ch4_bandwidth_swing   <= next_ch4_bandwidth_swing;
        end
    end

    // Read path and access status
    always_comb begin
        next_reg_rd_data    = rxa_pkg::RD_ZERO;
        next_reg_rd_valid   = reg_rd_en;
        next_reg_hit        = (reg_rd_en || reg_wr_en) && addr_in_slice;
        next_reg_wr_ignored = reg_wr_en && sel_reserved;
        if (reg_rd_en) begin
            case (reg_addr)
                rxa_pkg::OFS_CH3_BW_SWING: next_reg_rd_data = ch3_bandwidth_swing;
                rxa_pkg::OFS_CH3_GAIN_OFS: next_reg_rd_data = ch3_gain_offset_power;
                rxa_pkg::OFS_CH4_BW_SWING: next_reg_rd_data = ch4_bandwidth_swing;
                default:                   next_reg_rd_data = rxa_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rd_data    <= rxa_pkg::RD_ZERO;
            reg_rd_valid   <= 1'b0;
            reg_hit        <= 1'b0;
            reg_wr_ignored <= 1'b0;
        end else begin
            reg_rd_data    <= next_reg_rd_data;
            reg_rd_valid   <= next_reg_rd_valid;
            reg_hit        <= next_reg_hit;
            reg_wr_ignored <= next_reg_wr_ignored;
        end
    end

    // Field decoders
    rxa_bw_swing_decode u_ch3_bw_decode (
        .reg_value (ch3_bandwidth_swing),
        .bw_trim   (dec_ch3_bw_trim),
        .swing_mv  (dec_ch3_swing_mv)
    );

    rxa_bw_swing_decode u_ch4_bw_decode (
        .reg_value (ch4_bandwidth_swing),
        .bw_trim   (dec_ch4_bw_trim),
        .swing_mv  (dec_ch4_swing_mv)
    );

    rxa_gain_offset_decode u_ch3_gain_decode (
        .reg_value         (ch3_gain_offset_power),
        .channel_sleep     (dec_ch3_sleep),
        .output_buffer_off (dec_ch3_buf_off),
        .gain_atten_db     (dec_ch3_gain_db),
        .gain_code_na      (dec_ch3_gain_na),
        .offset_negative   (dec_ch3_ofs_neg),
        .offset_mag        (dec_ch3_ofs_mag)
    );

    // Channel 3 analog controls
    always_comb begin
        next_ch3_bw_trim_code        = ch3_bandwidth_swing[rxa_pkg::BW_MSB:rxa_pkg::BW_LSB];
        next_ch3_bw_trim             = dec_ch3_bw_trim;
        next_ch3_output_swing_code   = ch3_bandwidth_swing[rxa_pkg::SWING_MSB:rxa_pkg::SWING_LSB];
        next_ch3_output_swing_mv     = dec_ch3_swing_mv;
        next_ch3_channel_sleep       = dec_ch3_sleep;
        next_ch3_output_buffer_off   = dec_ch3_buf_off;
        next_ch3_gain_atten_db       = dec_ch3_gain_db;
        next_ch3_gain_code_na        = dec_ch3_gain_na;
        next_ch3_decision_offset_neg = dec_ch3_ofs_neg;
        next_ch3_decision_offset_mag = dec_ch3_ofs_mag;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ch3_bw_trim_code        <= rxa_pkg::BW_CODE_NOMINAL;
            ch3_bw_trim             <= rxa_pkg::RXA_BW_NOMINAL;
            ch3_output_swing_code   <= rxa_pkg::RST_CH3_BW_SWING[3:0];
            ch3_output_swing_mv     <= rxa_pkg::SWING_RST_MV;
            ch3_channel_sleep       <= 1'b0;
            ch3_output_buffer_off   <= 1'b0;
            ch3_gain_atten_db       <= rxa_pkg::GAIN_DB_NONE;
            ch3_gain_code_na        <= 1'b0;
            ch3_decision_offset_neg <= 1'b0;
            ch3_decision_offset_mag <= 3'h0;
        end else begin
            ch3_bw_trim_code        <= next_ch3_bw_trim_code;
            ch3_bw_trim             <= next_ch3_bw_trim;
            ch3_output_swing_code   <= next_ch3_output_swing_code;
            ch3_output_swing_mv     <= next_ch3_output_swing_mv;
            ch3_channel_sleep       <= next_ch3_channel_sleep;
            ch3_output_buffer_off   <= next_ch3_output_buffer_off;
            ch3_gain_atten_db       <= next_ch3_gain_atten_db;
            ch3_gain_code_na        <= next_ch3_gain_code_na;
            ch3_decision_offset_neg <= next_ch3_decision_offset_neg;
            ch3_decision_offset_mag <= next_ch3_decision_offset_mag;
        end
    end

    // Channel 4 bandwidth and swing controls
    always_comb begin
        next_ch4_bw_trim_code      = ch4_bandwidth_swing[rxa_pkg::BW_MSB:rxa_pkg::BW_LSB];
        next_ch4_bw_trim           = dec_ch4_bw_trim;
        next_ch4_output_swing_code = ch4_bandwidth_swing[rxa_pkg::SWING_MSB:rxa_pkg::SWING_LSB];
        next_ch4_output_swing_mv   = dec_ch4_swing_mv;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ch4_bw_trim_code      <= rxa_pkg::BW_CODE_NOMINAL;
            ch4_bw_trim           <= rxa_pkg::RXA_BW_NOMINAL;
            ch4_output_swing_code <= rxa_pkg::RST_CH4_BW_SWING[3:0];
            ch4_output_swing_mv   <= rxa_pkg::SWING_RST_MV;
        end else begin
            ch4_bw_trim_code      <= next_ch4_bw_trim_code;
            ch4_bw_trim           <= next_ch4_bw_trim;
            ch4_output_swing_code <= next_ch4_output_swing_code;
            ch4_output_swing_mv   <= next_ch4_output_swing_mv;
        end
    end

endmodule : rxa_channel_settings_bank

// File: rxa_bank_checker.sv
// Assertion checker for the channel settings bank
`timescale 1ns/10ps
module rxa_bank_checker (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic       reg_rd_valid,
    input wire logic       reg_hit,
    input wire logic       reg_wr_ignored,
    input wire logic [3:0] ch3_bw_trim_code,
    input wire logic [3:0] ch3_output_swing_code,
    input wire logic [9:0] ch3_output_swing_mv,
    input wire logic       ch3_channel_sleep,
    input wire logic       ch3_output_buffer_off,
    input wire logic [3:0] ch3_gain_atten_db,
    input wire logic       ch3_decision_offset_neg,
    input wire logic [2:0] ch3_decision_offset_mag,
    input wire logic [3:0] ch4_output_swing_code
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    logic       rsv;
    logic       rwa;
    logic       hit_c;
    logic       ign_c;
    logic [7:0] d1;
    logic [7:0] d2;
    assign rsv = (reg_addr >= 8'h0A && reg_addr <= 8'h0C)
               || (reg_addr >= 8'h0F && reg_addr <= 8'h12);
    assign rwa = reg_addr == 8'h0D || reg_addr == 8'h0E || reg_addr == 8'h13;
    assign hit_c = (reg_wr_en || reg_rd_en) && (rsv || rwa);
    assign ign_c = reg_wr_en && rsv;
    // Write data two cycles back
    always_ff @(posedge ref_clk) begin
        d1 <= reg_wr_data;
        d2 <= d1;
    end
    a_rd_valid_pulse: assert property (1'b1 |=> reg_rd_valid == $past(reg_rd_en))
        else $error("read valid does not follow read strobe");
    a_hit_window: assert property (1'b1 |=> reg_hit == $past(hit_c))
        else $error("hit flag wrong for address");
    a_wr_ign_flag: assert property (1'b1 |=> reg_wr_ignored == $past(ign_c))
        else $error("ignored flag wrong for write");
    a_rsvd_rd_zero: assert property (reg_rd_en && !rwa |=> reg_rd_valid && reg_rd_data == 8'h00)
        else $error("reserved read not zero");
    a_rsvd_wr_still: assert property (reg_wr_en && !rwa |=> ##1 $stable({ch3_bw_trim_code,
        ch3_output_swing_code, ch3_channel_sleep, ch4_output_swing_code}))
        else $error("reserved write changed a setting");
    a_bw_code: assert property (reg_wr_en && reg_addr == 8'h0D |=> ##1 ch3_bw_trim_code == d2[7:4])
        else $error("bandwidth code wrong");
    a_swing_map: assert property (reg_wr_en && reg_addr == 8'h0D |=> ##1 ch3_output_swing_mv ==
        (d2[3] ? 10'h0FA + 10'h032 * d2[2:0] : 10'h032 * d2[2:0]))
        else $error("swing value wrong");
    a_sleep_buf: assert property (reg_wr_en && reg_addr == 8'h0E |=> ##1
        ch3_channel_sleep == d2[7] && ch3_output_buffer_off == d2[6])
        else $error("sleep or buffer control wrong");
    a_gain_db: assert property (reg_wr_en && reg_addr == 8'h0E |=> ##1
        ch3_gain_atten_db == (d2[5] ? {d2[4], ~d2[4], 2'b00} : 4'h0))
        else $error("gain attenuation wrong");
    a_offset_sm: assert property (reg_wr_en && reg_addr == 8'h0E |=> ##1
        ch3_decision_offset_mag == d2[2:0]
        && ch3_decision_offset_neg == (d2[3] && d2[2:0] != 3'h0))
        else $error("decision offset wrong");
    a_ch4_swing: assert property (reg_wr_en && reg_addr == 8'h13 |=> ##1
        ch4_output_swing_code == d2[3:0])
        else $error("channel 4 swing code wrong");
    a_reset_clear: assert property ($rose(reset_n) |-> ch3_bw_trim_code == 4'h0
        && !ch3_channel_sleep && ch4_output_swing_code == 4'h0)
        else $error("settings not cleared by reset");
endmodule : rxa_bank_checker

// File: rxa_host_model.sv
// Host controller model driving the register strobes
`timescale 1ns/10ps
module rxa_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wr_data
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
    end
    // Entered at a falling edge; answer sampled one cycle on
    task access(input logic we, input logic re, input logic [7:0] a, input logic [7:0] d,
                input logic last, output logic [7:0] q, output logic v);
        reg_wr_en = we;
        reg_rd_en = re;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge ref_clk);
        q = reg_rd_data;
        v = reg_rd_valid;
        if (last) begin
            reg_wr_en = 1'b0;
            reg_rd_en = 1'b0;
            reg_addr = ~reg_addr;
            reg_wr_data = ~reg_wr_data;
            @(negedge ref_clk);
        end
    endtask : access
endmodule : rxa_host_model

// File: test_rxa_channel_settings_bank.sv
// Self-checking bench for the channel settings bank
`timescale 1ns/10ps
module test_rxa_channel_settings_bank;
    logic                  ref_clk, reset_n, reg_wr_en, reg_rd_en, reg_rd_valid, v;
    logic                  reg_hit, reg_wr_ignored, ch3_channel_sleep, ch3_output_buffer_off;
    logic                  ch3_gain_code_na, ch3_decision_offset_neg;
    logic [7:0]            reg_addr, reg_wr_data, reg_rd_data, q, d;
    logic [3:0]            ch3_bw_trim_code, ch3_output_swing_code, ch3_gain_atten_db;
    logic [3:0]            ch4_bw_trim_code, ch4_output_swing_code;
    logic [9:0]            ch3_output_swing_mv, ch4_output_swing_mv;
    logic [2:0]            ch3_decision_offset_mag;
    rxa_pkg::rxa_bw_trim_t ch3_bw_trim, ch4_bw_trim;
    logic [7:0]            mem [0:255];
    logic [31:0]           rnd;
    int                    failures, num_checks;
    rxa_channel_settings_bank u_rxa_channel_settings_bank (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit), .reg_wr_ignored(reg_wr_ignored),
        .ch3_bw_trim_code(ch3_bw_trim_code), .ch3_bw_trim(ch3_bw_trim),
        .ch3_output_swing_code(ch3_output_swing_code), .ch3_output_swing_mv(ch3_output_swing_mv),
        .ch3_channel_sleep(ch3_channel_sleep), .ch3_output_buffer_off(ch3_output_buffer_off),
        .ch3_gain_atten_db(ch3_gain_atten_db), .ch3_gain_code_na(ch3_gain_code_na),
        .ch3_decision_offset_neg(ch3_decision_offset_neg),
        .ch3_decision_offset_mag(ch3_decision_offset_mag),
        .ch4_bw_trim_code(ch4_bw_trim_code), .ch4_bw_trim(ch4_bw_trim),
        .ch4_output_swing_code(ch4_output_swing_code), .ch4_output_swing_mv(ch4_output_swing_mv)
    );
    rxa_host_model u_rxa_host_model (
        .ref_clk(ref_clk), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data)
    );
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic int mv_exp(input int c);
        return c < 8 ? c * 50 : 250 + (c - 8) * 50;
    endfunction : mv_exp
    function automatic rxa_pkg::rxa_bw_trim_t bw_exp(input int c);
        if (c == 0) return rxa_pkg::RXA_BW_NOMINAL;
        if (c == 7) return rxa_pkg::RXA_BW_LOWER;
        if (c == 15) return rxa_pkg::RXA_BW_RAISE;
        return rxa_pkg::RXA_BW_OTHER;
    endfunction : bw_exp
    function automatic logic [7:0] rd_exp(input logic [7:0] a);
        return (a == 8'h0D || a == 8'h0E || a == 8'h13) ? mem[a] : 8'h00;
    endfunction : rd_exp
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("FAIL %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] dt, input logic last);
        u_rxa_host_model.access(1'b1, 1'b0, a, dt, last, q, v);
        if (a == 8'h0D || a == 8'h0E || a == 8'h13) mem[a] = dt;
    endtask : wr
    task rd_range(input int lo, input int hi);
        for (int a = lo; a <= hi; a++) begin
            u_rxa_host_model.access(1'b0, 1'b1, a[7:0], 8'h00, a == hi, q, v);
            chk("rd_valid", 32'h1, {31'h0, v});
            chk("rd_data", {24'h0, rd_exp(a[7:0])}, {24'h0, q});
        end
    endtask : rd_range
    task chk_dec;
        logic [7:0] b, g, c;
        b = mem[8'h0D];
        g = mem[8'h0E];
        c = mem[8'h13];
        chk("bw_code", b[7:4], ch3_bw_trim_code);
        chk("bw_trim", bw_exp(b[7:4]), ch3_bw_trim);
        chk("swing_code", b[3:0], ch3_output_swing_code);
        chk("swing_mv", mv_exp(b[3:0]), ch3_output_swing_mv);
        chk("sleep", g[7], ch3_channel_sleep);
        chk("buf_off", g[6], ch3_output_buffer_off);
        chk("gain_db", g[5] ? {g[4], ~g[4], 2'b00} : 4'h0, ch3_gain_atten_db);
        chk("ofs_neg", g[3] && g[2:0] != 3'h0, ch3_decision_offset_neg);
        chk("ofs_mag", g[2:0], ch3_decision_offset_mag);
        chk("ch4_trim", bw_exp(c[7:4]), ch4_bw_trim);
        chk("ch4_mv", mv_exp(c[3:0]), ch4_output_swing_mv);
        chk("gain_na", g[5:4] == 2'h1, ch3_gain_code_na);
        chk("ch4_code", c[7:4], ch4_bw_trim_code);
    endtask : chk_dec
    task conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude();
    end
    initial begin
        reset_n = 1'b0;
        failures = 0;
        num_checks = 0;
        rnd = 32'h0001_3D88;
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        rd_range(8'h08, 8'h15);
        chk_dec();
        for (int i = 0; i < 16; i++) begin
            wr(8'h0D, {i[3:0], 4'hF - i[3:0]}, 1'b0);
            wr(8'h13, {4'hF - i[3:0], i[3:0]}, 1'b0);
            wr(8'h0E, {i[1:0], (i % 3 == 0) ? 2'h0 : {1'b1, i % 3 == 2}, i[3:0]}, 1'b1);
            chk_dec();
        end
        for (int a = 8'h0A; a <= 8'h14; a++)
            if (!(a inside {8'h0D, 8'h0E, 8'h13})) wr(a[7:0], 8'hFF, a == 8'h14);
        chk_dec();
        rd_range(8'h0A, 8'h14);
        u_rxa_host_model.access(1'b1, 1'b1, 8'h0E, 8'h35, 1'b1, q, v);
        chk("rd_old", {24'h0, mem[8'h0E]}, {24'h0, q});
        mem[8'h0E] = 8'h35;
        chk_dec();
        for (int i = 0; i < 40; i++) begin
            rnd = xs(rnd);
            d = rnd[15:8];
            if (d[5:4] == 2'h1) d[4] = 1'b0;
            wr(8'h0A + {4'h0, rnd[3:0] % 4'hA}, d, rnd[20] || i == 39);
        end
        rd_range(8'h0A, 8'h13);
        chk_dec();
        reset_n = 1'b0;
        @(negedge ref_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        rd_range(8'h0D, 8'h13);
        chk_dec();
        conclude();
    end
endmodule : test_rxa_channel_settings_bank
bind rxa_channel_settings_bank rxa_bank_checker u_rxa_bank_checker (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit), .reg_wr_ignored(reg_wr_ignored),
    .ch3_bw_trim_code(ch3_bw_trim_code), .ch3_output_swing_code(ch3_output_swing_code),
    .ch3_output_swing_mv(ch3_output_swing_mv), .ch3_channel_sleep(ch3_channel_sleep),
    .ch3_output_buffer_off(ch3_output_buffer_off), .ch3_gain_atten_db(ch3_gain_atten_db),
    .ch3_decision_offset_neg(ch3_decision_offset_neg),
    .ch3_decision_offset_mag(ch3_decision_offset_mag),
    .ch4_output_swing_code(ch4_output_swing_code)
);
